// File: core/didc_core.sv
// module: digital input command decoder, terminals and link word to commands
`timescale 1ns/1ps
module didc_core (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire didc_pkg::didc_cfg_t cfg,
	input wire logic [didc_pkg::NTERM-1:0] term_in,
	input wire logic lcw_wr,
	input wire logic [didc_pkg::LCW_W-1:0] lcw_wdata,
	output logic [didc_pkg::LCW_W-1:0] lcw_rdata,
	output logic [didc_pkg::NFUNC-1:0] func_out,
	output didc_pkg::didc_cmd_t cmd_out
);
	typedef struct packed {
		logic [didc_pkg::NTERM-1:0] term_q;
		logic [didc_pkg::LCW_W-1:0] lcw_q;
		logic [didc_pkg::NFUNC-1:0] func_q;
		didc_pkg::didc_cmd_t cmd_q;
	} didc_state_t;

	didc_state_t st;
	didc_state_t nx;

	logic [didc_pkg::NTERM-1:0] dec_valid;
	logic [didc_pkg::NTERM-1:0] dec_active;
	logic [didc_pkg::NTERM-1:0][6:0] dec_fn;
	logic [didc_pkg::NFUNC-1:0] hit_term;
	logic [didc_pkg::NFUNC-1:0] hit_link;
	logic [didc_pkg::NFUNC-1:0] assigned;
	logic link_active;
	logic le;

	genvar gi;
	generate
		for (gi = 0; gi < didc_pkg::NTERM; gi++) begin : g_term
			didc_term_dec #(
				.RUN_TERM(gi >= didc_pkg::TERM_FWD)
			) u_dec (
				.code(cfg.term_code[gi]),
				.level(st.term_q[gi]),
				.valid(dec_valid[gi]),
				.fn(dec_fn[gi]),
				.active(dec_active[gi])
			);
		end
	endgenerate

	// gather every terminal and link bit onto the function it is set to
	always_comb begin
		hit_term = '0;
		hit_link = '0;
		assigned = '0;
		for (int i = 0; i < didc_pkg::NTERM; i++) begin
			if (dec_valid[i]) begin
				assigned[dec_fn[i]] = 1'b1;
				if (dec_active[i])
					hit_term[dec_fn[i]] = 1'b1;
				if (st.lcw_q[didc_pkg::lcw_pos(i)])
					hit_link[dec_fn[i]] = 1'b1;
			end
		end
	end

	// bus option ignores the second setting
	always_comb begin
		if (cfg.bus_option)
			link_active = cfg.link_function_setting != 2'h0;
		else
			link_active = cfg.link_function_setting != 2'h0 &&
				cfg.bus_link_function_setting != 2'h0;
		// with no terminal set to link enable the link holds control
		if (assigned[didc_pkg::FN_LINK_EN])
			le = link_active && hit_term[didc_pkg::FN_LINK_EN];
		else
			le = link_active;
	end

	always_comb begin
		nx = st;
		if (ce) begin
			nx.term_q = term_in;
			if (lcw_wr)
				nx.lcw_q = lcw_wdata;
			for (int f = 0; f < didc_pkg::NFUNC; f++) begin
				unique case (didc_pkg::fn_class(7'(f)))
					didc_pkg::CL_TERM_ONLY:
						nx.func_q[f] = hit_term[f];
					didc_pkg::CL_OR:
						nx.func_q[f] = hit_term[f] ||
							(link_active && hit_link[f]);
					didc_pkg::CL_PRIO:
						nx.func_q[f] = le ? hit_link[f] : hit_term[f];
					didc_pkg::CL_GENERAL:
						nx.func_q[f] = le ? hit_link[f] : hit_term[f];
				endcase
			end
			// named view, taken from the same next values
			nx.cmd_q.forward_run = nx.func_q[didc_pkg::FN_FWD];
			nx.cmd_q.reverse_run = nx.func_q[didc_pkg::FN_REV];
			nx.cmd_q.second_forward_run =
				nx.func_q[didc_pkg::FN_SECOND_FORWARD_RUN];
			nx.cmd_q.second_reverse_run =
				nx.func_q[didc_pkg::FN_SECOND_REVERSE_RUN];
			nx.cmd_q.run_source_select =
				nx.func_q[didc_pkg::FN_RUN_SRC];
			nx.cmd_q.freq_source_select =
				nx.func_q[didc_pkg::FN_FREQ_SRC];
			nx.cmd_q.link_enable_cmd = nx.func_q[didc_pkg::FN_LINK_EN];
			nx.cmd_q.external_alarm_trip =
				nx.func_q[didc_pkg::FN_EXT_ALARM];
			nx.cmd_q.force_stop = nx.func_q[didc_pkg::FN_FORCE_STOP];
			nx.cmd_q.dc_brake_cmd = nx.func_q[didc_pkg::FN_DC_BRAKE];
			nx.cmd_q.mains_switch_50 =
				nx.func_q[didc_pkg::FN_MAINS_50];
			nx.cmd_q.mains_switch_60 =
				nx.func_q[didc_pkg::FN_MAINS_60];
			nx.cmd_q.mains_sequence_50 = nx.func_q[didc_pkg::FN_SEQ_50];
			nx.cmd_q.mains_sequence_60 = nx.func_q[didc_pkg::FN_SEQ_60];
			nx.cmd_q.dew_protect = nx.func_q[didc_pkg::FN_DEW];
			nx.cmd_q.freq_up = nx.func_q[didc_pkg::FN_FREQ_UP];
			nx.cmd_q.freq_down = nx.func_q[didc_pkg::FN_FREQ_DOWN];
			nx.cmd_q.keypad_write_enable =
				nx.func_q[didc_pkg::FN_KEYPAD_WE];
			nx.cmd_q.loop_id_reset =
				nx.func_q[didc_pkg::FN_LOOP_RST];
			nx.cmd_q.loop_integral_hold =
				nx.func_q[didc_pkg::FN_LOOP_HOLD];
			nx.cmd_q.pump_motor_enable =
				nx.func_q[didc_pkg::FN_PUMP4:didc_pkg::FN_PUMP1];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
			st.lcw_q <= didc_pkg::LCW_RESET;
		end else begin
			st <= nx;
		end
	end

	assign lcw_rdata = st.lcw_q;
	assign func_out = st.func_q;
	assign cmd_out = st.cmd_q;

	// checks: inputs are taken one edge, commands appear the next

	a_keypad_neg_code: assert property (@(posedge clk) disable iff (!rst_b)
		ce && cfg.term_code[0] ==
		didc_pkg::code_of(didc_pkg::FN_KEYPAD_WE, 1'b1) &&
		!st.term_q[0] && !le |=> func_out[didc_pkg::FN_KEYPAD_WE])
		else $error("active-low keypad write code not decoded");

	a_or_two_terms: assert property (@(posedge clk) disable iff (!rst_b)
		ce && !le && cfg.term_code[1] ==
		didc_pkg::code_of(didc_pkg::FN_KEYPAD_WE, 1'b0) &&
		cfg.term_code[2] == cfg.term_code[1] &&
		(st.term_q[1] || st.term_q[2])
		|=> func_out[didc_pkg::FN_KEYPAD_WE])
		else $error("shared function not ORed over terminals");

	a_alarm_inverted: assert property (@(posedge clk) disable iff (!rst_b)
		ce && cfg.term_code[0] ==
		didc_pkg::code_of(didc_pkg::FN_EXT_ALARM, 1'b0) &&
		!st.term_q[0] |=> cmd_out.external_alarm_trip)
		else $error("alarm code 9 not active-off");

	a_stop_active_on: assert property (@(posedge clk) disable iff (!rst_b)
		ce && !link_active && (cfg.term_code ==
		{didc_pkg::NTERM{didc_pkg::code_of(didc_pkg::FN_FORCE_STOP,
		1'b1)}}) ##0 (st.term_q == '0) |=> !cmd_out.force_stop)
		else $error("stop code 1030 asserted with terminals off");

	a_pos_only_reject: assert property (@(posedge clk) disable iff (!rst_b)
		ce && (cfg.term_code ==
		{didc_pkg::NTERM{didc_pkg::code_of(didc_pkg::FN_DC_BRAKE, 1'b1)}})
		|=> !cmd_out.dc_brake_cmd)
		else $error("negative code accepted for positive-only brake");

	a_run_on_run_only: assert property (@(posedge clk) disable iff (!rst_b)
		ce && cfg.term_code[didc_pkg::TERM_FWD] !=
		didc_pkg::code_of(didc_pkg::FN_FWD, 1'b0) &&
		cfg.term_code[didc_pkg::TERM_REV] !=
		didc_pkg::code_of(didc_pkg::FN_FWD, 1'b0)
		|=> !cmd_out.forward_run)
		else $error("forward run taken from a general terminal");

	a_link_en_code: assert property (@(posedge clk) disable iff (!rst_b)
		ce && link_active && cfg.term_code[4] ==
		didc_pkg::code_of(didc_pkg::FN_LINK_EN, 1'b1) && !st.term_q[4]
		|-> le ##1 cmd_out.link_enable_cmd)
		else $error("link enable code 1024 not decoded");

	a_pump_motor: assert property (@(posedge clk) disable iff (!rst_b)
		ce && !le && cfg.term_code[0] ==
		didc_pkg::code_of(didc_pkg::FN_PUMP1, 1'b0) && st.term_q[0]
		|=> cmd_out.pump_motor_enable[0] && func_out[51])
		else $error("pump motor 1 enable missing");

	a_term_only_link: assert property (@(posedge clk) disable iff (!rst_b)
		ce && st.term_q == '0 && !st.cmd_q.mains_sequence_50
		|=> !cmd_out.dew_protect && !cmd_out.mains_sequence_50)
		else $error("terminal-only function raised with terminals off");

	a_or_link_bit: assert property (@(posedge clk) disable iff (!rst_b)
		ce && link_active && cfg.term_code[4] ==
		didc_pkg::code_of(didc_pkg::FN_FORCE_STOP, 1'b1) &&
		st.lcw_q[6] |=> cmd_out.force_stop)
		else $error("ORing function ignored the link bit");

	a_prio_forced_off: assert property (@(posedge clk) disable iff (!rst_b)
		ce && le && st.lcw_q == '0
		|=> !cmd_out.freq_up && !cmd_out.loop_id_reset &&
		cmd_out.pump_motor_enable == 4'h0)
		else $error("terminal passed through while link enabled");

	a_lcw_write: assert property (@(posedge clk) disable iff (!rst_b)
		ce && lcw_wr |=> lcw_rdata == $past(lcw_wdata))
		else $error("link control word write lost");

	a_serial_setting: assert property (@(posedge clk) disable iff (!rst_b)
		!cfg.bus_option && cfg.bus_link_function_setting == 2'h0
		|-> !le && !link_active)
		else $error("serial link active without second setting");

	a_ce_freeze: assert property (@(posedge clk) disable iff (!rst_b)
		!ce |=> $stable(func_out) && $stable(lcw_rdata) &&
		$stable(cmd_out))
		else $error("state moved while clock enable low");

	a_two_edge_path: assert property (@(posedge clk) disable iff (!rst_b)
		ce && cfg.term_code[0] ==
		didc_pkg::code_of(didc_pkg::FN_EXT_ALARM, 1'b1) && term_in[0]
		##1 ce && $stable(cfg) |=> cmd_out.external_alarm_trip)
		else $error("terminal level not decoded two edges later");

	a_no_code_quiet: assert property (@(posedge clk) disable iff (!rst_b)
		ce && !link_active && dec_valid == '0 |=> func_out == '0)
		else $error("function raised with no terminal assigned");

	a_freq_up_term: assert property (@(posedge clk) disable iff (!rst_b)
		ce && !le && cfg.term_code[0] ==
		didc_pkg::code_of(didc_pkg::FN_FREQ_UP, 1'b0) && st.term_q[0]
		|=> cmd_out.freq_up)
		else $error("increase frequency not decoded");

	a_mains_switch_term: assert property (@(posedge clk) disable iff (!rst_b)
		ce && cfg.term_code[0] ==
		didc_pkg::code_of(didc_pkg::FN_MAINS_50, 1'b0) && st.term_q[0]
		|=> cmd_out.mains_switch_50)
		else $error("50 Hz mains switch not decoded");

	a_freq_src_neg: assert property (@(posedge clk) disable iff (!rst_b)
		ce && !le && cfg.term_code[0] ==
		didc_pkg::code_of(didc_pkg::FN_FREQ_SRC, 1'b1) && !st.term_q[0]
		|=> cmd_out.freq_source_select)
		else $error("active-low frequency source select not decoded");

	a_run_src_term: assert property (@(posedge clk) disable iff (!rst_b)
		ce && !le && cfg.term_code[0] ==
		didc_pkg::code_of(didc_pkg::FN_RUN_SRC, 1'b0) && st.term_q[0]
		|=> cmd_out.run_source_select)
		else $error("run source select not decoded");

	a_link_mirror_bit: assert property (@(posedge clk) disable iff (!rst_b)
		ce && le && cfg.term_code[didc_pkg::TERM_FWD] ==
		didc_pkg::code_of(didc_pkg::FN_FREQ_DOWN, 1'b0) && st.lcw_q[13]
		|=> cmd_out.freq_down)
		else $error("forward terminal link bit not mirrored");
endmodule

// File: core/didc_pkg.sv
// package: constants, types and decoders of the digital input command decoder
// Operation
// - each terminal takes its function from its own configuration code
// - a function assigned to several terminals is the OR of them
// - negative-logic code equals positive-logic code plus 1000
// - external alarm and forced stop use inverted coding: 9/30 are active-off
// - dc brake, mains, dew, sequences, run 2, run accept positive codes only
// - main run codes 98 and 99 only on the forward and reverse terminals
// - code 24 or 1024 gives the link enable command
// - codes 51 to 54 give the four pump motor enables
// - codes 17 and 18 give increase and decrease frequency
// - codes 33 and 34 give loop id reset and integral hold
// - code 87 gives run source select, 88 and 89 second run commands
// - code 11 gives the frequency source select
// - codes 15 and 16 give the 50 Hz and 60 Hz mains switch
// - general functions come from the terminal or the link word bit
// - terminal-only functions ignore the link word completely
// - ORing functions assert on terminal or link bit
// - link-priority functions force terminals off while link enable is on
// - link word bits 2-6, 13, 14 mirror the seven terminals
// - serial link needs both link settings, bus option only the first
package didc_pkg;
	localparam int NTERM = 7;
	localparam int NFUNC = 100;
	localparam int CODE_W = 11;
	localparam int FN_W = 7;
	localparam int LCW_W = 16;
	localparam int TERM_FWD = 5;
	localparam int TERM_REV = 6;
	localparam logic [10:0] NEG_OFFSET = 11'h03e8;
	localparam logic [10:0] FN_LIMIT = 11'h0064;
	localparam logic [15:0] LCW_RESET = 16'h0000;
	localparam logic [3:0] LCW_BIT_X1 = 4'h2;
	localparam logic [3:0] LCW_BIT_FWD = 4'hd;
	localparam logic [3:0] LCW_BIT_REV = 4'he;

	localparam logic [6:0] FN_EXT_ALARM = 7'h09;
	localparam logic [6:0] FN_FREQ_SRC = 7'h0b;
	localparam logic [6:0] FN_DC_BRAKE = 7'h0d;
	localparam logic [6:0] FN_MAINS_50 = 7'h0f;
	localparam logic [6:0] FN_MAINS_60 = 7'h10;
	localparam logic [6:0] FN_FREQ_UP = 7'h11;
	localparam logic [6:0] FN_FREQ_DOWN = 7'h12;
	localparam logic [6:0] FN_KEYPAD_WE = 7'h13;
	localparam logic [6:0] FN_LINK_EN = 7'h18;
	localparam logic [6:0] FN_FORCE_STOP = 7'h1e;
	localparam logic [6:0] FN_LOOP_RST = 7'h21;
	localparam logic [6:0] FN_LOOP_HOLD = 7'h22;
	localparam logic [6:0] FN_DEW = 7'h27;
	localparam logic [6:0] FN_SEQ_50 = 7'h28;
	localparam logic [6:0] FN_SEQ_60 = 7'h29;
	localparam logic [6:0] FN_PUMP1 = 7'h33;
	localparam logic [6:0] FN_PUMP4 = 7'h36;
	localparam logic [6:0] FN_RUN_SRC = 7'h57;
	localparam logic [6:0] FN_SECOND_FORWARD_RUN = 7'h58;
	localparam logic [6:0] FN_SECOND_REVERSE_RUN = 7'h59;
	localparam logic [6:0] FN_FWD = 7'h62;
	localparam logic [6:0] FN_REV = 7'h63;

	typedef enum logic [3:0] {
		CL_GENERAL = 4'h1,
		CL_TERM_ONLY = 4'h2,
		CL_OR = 4'h4,
		CL_PRIO = 4'h8
	} didc_class_t;

	typedef struct packed {
		logic [NTERM-1:0][CODE_W-1:0] term_code;
		logic [1:0] link_function_setting;
		logic [1:0] bus_link_function_setting;
		logic bus_option;
	} didc_cfg_t;

	typedef struct packed {
		logic forward_run;
		logic reverse_run;
		logic second_forward_run;
		logic second_reverse_run;
		logic run_source_select;
		logic freq_source_select;
		logic link_enable_cmd;
		logic external_alarm_trip;
		logic force_stop;
		logic dc_brake_cmd;
		logic mains_switch_50;
		logic mains_switch_60;
		logic mains_sequence_50;
		logic mains_sequence_60;
		logic dew_protect;
		logic freq_up;
		logic freq_down;
		logic keypad_write_enable;
		logic loop_id_reset;
		logic loop_integral_hold;
		logic [3:0] pump_motor_enable;
	} didc_cmd_t;

	function automatic logic [3:0] lcw_pos(input int i);
		if (i < TERM_FWD)
			return LCW_BIT_X1 + 4'(i);
		return (i == TERM_FWD) ? LCW_BIT_FWD : LCW_BIT_REV;
	endfunction

	function automatic logic [10:0] code_of(input logic [6:0] f,
		input logic neg);
		return {4'h0, f} + (neg ? NEG_OFFSET : 11'h0000);
	endfunction

	function automatic logic fn_listed(input logic [6:0] f);
		case (f)
			7'h00, 7'h01, 7'h02, 7'h06, 7'h07, 7'h08, 7'h09, 7'h0b,
			7'h0d, 7'h0f, 7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h15,
			7'h16, 7'h18, 7'h19, 7'h1a, 7'h1e, 7'h21, 7'h22, 7'h23,
			7'h26, 7'h27, 7'h28, 7'h29, 7'h32, 7'h33, 7'h34, 7'h35,
			7'h36, 7'h57, 7'h58, 7'h59, 7'h62, 7'h63: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic fn_pos_only(input logic [6:0] f);
		return f == FN_DC_BRAKE || f == FN_MAINS_50 || f == FN_MAINS_60 ||
			f == FN_DEW || f == FN_SEQ_50 || f == FN_SEQ_60 ||
			f == FN_SECOND_FORWARD_RUN || f == FN_SECOND_REVERSE_RUN || f == FN_FWD || f == FN_REV;
	endfunction

	function automatic logic fn_inv_default(input logic [6:0] f);
		return f == FN_EXT_ALARM || f == FN_FORCE_STOP;
	endfunction

	function automatic didc_class_t fn_class(input logic [6:0] f);
		if (f == FN_DC_BRAKE || f == FN_MAINS_50 || f == FN_MAINS_60 ||
			f == FN_LINK_EN || f == FN_DEW || f == FN_SEQ_50 ||
			f == FN_SEQ_60)
			return CL_TERM_ONLY;
		if (f == 7'h07 || f == FN_EXT_ALARM || f == FN_FORCE_STOP)
			return CL_OR;
		if (f == FN_FREQ_UP || f == FN_FREQ_DOWN || f == FN_LOOP_RST ||
			f == FN_LOOP_HOLD || (f >= FN_PUMP1 && f <= FN_PUMP4) ||
			f == FN_RUN_SRC || f == FN_SECOND_FORWARD_RUN || f == FN_SECOND_REVERSE_RUN)
			return CL_PRIO;
		return CL_GENERAL;
	endfunction
endpackage

// File: core/didc_term_dec.sv
// module: decodes one terminal's configuration code and input level
`timescale 1ns/1ps
module didc_term_dec #(
	parameter bit RUN_TERM = 1'b0
) (
	input wire logic [10:0] code,
	input wire logic level,
	output logic valid,
	output logic [6:0] fn,
	output logic active
);
	logic neg_code;
	logic [10:0] base;
	logic inv;

	always_comb begin
		neg_code = code >= didc_pkg::NEG_OFFSET;
		base = neg_code ? code - didc_pkg::NEG_OFFSET : code;
		fn = base[6:0];
		valid = base < didc_pkg::FN_LIMIT &&
			didc_pkg::fn_listed(fn) &&
			!(neg_code && didc_pkg::fn_pos_only(fn)) &&
			!((fn == didc_pkg::FN_FWD || fn == didc_pkg::FN_REV) &&
			!RUN_TERM);
		// alarm and stop codes run the other way round
		inv = neg_code ^ didc_pkg::fn_inv_default(fn);
		active = valid && (level ^ inv);
	end
endmodule

// File: tb/didc_field_model.sv
// partner model: contacts on the seven terminals and the host link word
`timescale 1ns/1ps
module didc_field_model (
	input wire logic clk,
	output logic [didc_pkg::NTERM-1:0] term_in,
	output logic lcw_wr,
	output logic [didc_pkg::LCW_W-1:0] lcw_wdata
);
	initial begin
		term_in = 7'h00;
		lcw_wr = 1'b0;
		lcw_wdata = 16'h0000;
	end

	// contacts are plain levels, moved just after a clock edge
	task automatic set_contact(input int i, input logic v);
		term_in[i] = v;
	endtask

	// bits 2..6, 13 and 14 stand for the seven terminals
	task automatic host_write(input logic [15:0] w);
		lcw_wr = 1'b1;
		lcw_wdata = w;
		@(posedge clk);
		#1;
		lcw_wr = 1'b0;
		// released data must not keep showing the old word
		lcw_wdata = ~w;
	endtask
endmodule

// File: tb/digital_input_command_decoder_tb.sv
// testbench: terminal codes, link word and command outputs of the decoder
`timescale 1ns/1ps
module digital_input_command_decoder_tb;
	localparam logic [10:0] BAD = 11'h07ff;
	localparam logic [10:0] NEG = didc_pkg::NEG_OFFSET;
	logic clk;
	logic rst_b;
	logic ce;
	didc_pkg::didc_cfg_t cfg;
	logic [6:0] term_in;
	logic lcw_wr;
	logic [15:0] lcw_wdata;
	logic [15:0] lcw_rdata;
	logic [99:0] func_out;
	didc_pkg::didc_cmd_t cmd_out;
	int error_cnt;
	int n_checks;
	logic [6:0] fl [19] = '{7'h0b, 7'h0d, 7'h0f, 7'h10, 7'h11, 7'h12,
		7'h13, 7'h21, 7'h22, 7'h27, 7'h28, 7'h29, 7'h33, 7'h34, 7'h35,
		7'h36, 7'h57, 7'h58, 7'h59};
	bit po [19] = '{0, 1, 1, 1, 0, 0, 0, 0, 0, 1, 1, 1, 0, 0, 0, 0, 0, 1, 1};

	didc_core dut (
		.clk(clk),
		.rst_b(rst_b),
		.ce(ce),
		.cfg(cfg),
		.term_in(term_in),
		.lcw_wr(lcw_wr),
		.lcw_wdata(lcw_wdata),
		.lcw_rdata(lcw_rdata),
		.func_out(func_out),
		.cmd_out(cmd_out)
	);

	didc_field_model field (
		.clk(clk),
		.term_in(term_in),
		.lcw_wr(lcw_wr),
		.lcw_wdata(lcw_wdata)
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk_bit(input logic a, input logic e);
		n_checks++;
		if (a !== e) begin
			error_cnt++;
			$display("FAIL %0t command got %b want %b", $time, a, e);
		end
	endtask

	task automatic chk_word(input logic [15:0] a, input logic [15:0] e);
		n_checks++;
		if (a !== e) begin
			error_cnt++;
			$display("FAIL %0t link word got %h want %h", $time, a, e);
		end
	endtask

	task automatic stop_test;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic clr;
		for (int i = 0; i < 7; i++) begin
			cfg.term_code[i] = BAD;
			field.set_contact(i, 1'b0);
		end
		tick(3);
	endtask

	// two edges from contact to output, a third for margin
	task automatic run(input int t, input logic [10:0] c, input logic v,
		input int f, input logic e);
		cfg.term_code[t] = c;
		field.set_contact(t, v);
		tick(3);
		chk_bit(func_out[f], e);
	endtask

	initial begin
		#1_000_000;
		error_cnt++;
		$display("FAIL %0t run timed out", $time);
		stop_test();
	end

	initial begin
		error_cnt = 0;
		n_checks = 0;
		rst_b = 1'b0;
		ce = 1'b1;
		cfg = '0;
		for (int i = 0; i < 7; i++)
			cfg.term_code[i] = BAD;
		repeat (10) @(posedge clk);
		#1;
		chk_word(lcw_rdata, 16'h0000);
		rst_b = 1'b1;
		tick(1);
		field.host_write(16'ha5c3);
		tick(1);
		chk_word(lcw_rdata, 16'ha5c3);
		// a write while frozen must leave the word alone
		ce = 1'b0;
		field.host_write(16'h0000);
		ce = 1'b1;
		tick(1);
		chk_word(lcw_rdata, 16'ha5c3);
		field.host_write(16'h0000);
		for (int k = 0; k < 19; k++) begin
			run(0, {4'h0, fl[k]}, 1'b1, int'(fl[k]), 1'b1);
			run(0, {4'h0, fl[k]}, 1'b0, int'(fl[k]), 1'b0);
			run(0, NEG + {4'h0, fl[k]}, 1'b0, int'(fl[k]), !po[k]);
			clr();
		end
		run(0, NEG + 11'h0009, 1'b1, 9, 1'b1);
		run(0, 11'h0009, 1'b1, 9, 1'b0);
		run(0, 11'h0009, 1'b0, 9, 1'b1);
		chk_bit(cmd_out.external_alarm_trip, 1'b1);
		run(1, 11'h001e, 1'b0, 30, 1'b1);
		chk_bit(cmd_out.force_stop, 1'b1);
		run(1, NEG + 11'h001e, 1'b0, 30, 1'b0);
		clr();
		for (int i = 0; i < 7; i++)
			cfg.term_code[i] = NEG + 11'h001e;
		tick(3);
		chk_bit(cmd_out.force_stop, 1'b0);
		for (int i = 0; i < 7; i++)
			cfg.term_code[i] = NEG + 11'h000d;
		tick(3);
		chk_bit(cmd_out.dc_brake_cmd, 1'b0);
		clr();
		run(0, 11'h0062, 1'b1, 98, 1'b0);
		run(5, 11'h0062, 1'b1, 98, 1'b1);
		run(6, 11'h0063, 1'b1, 99, 1'b1);
		chk_bit(cmd_out.reverse_run, 1'b1);
		// reset in mid-run: word cleared, commands back two edges later
		field.host_write(16'h0123);
		rst_b = 1'b0;
		tick(1);
		chk_bit(cmd_out.reverse_run, 1'b0);
		chk_word(lcw_rdata, 16'h0000);
		rst_b = 1'b1;
		tick(1);
		chk_bit(cmd_out.reverse_run, 1'b0);
		tick(1);
		chk_bit(cmd_out.reverse_run, 1'b1);
		clr();
		run(2, 11'h0013, 1'b1, 19, 1'b1);
		run(1, 11'h0013, 1'b1, 19, 1'b1);
		run(2, 11'h0013, 1'b0, 19, 1'b1);
		run(1, 11'h0013, 1'b0, 19, 1'b0);
		clr();
		cfg.link_function_setting = 2'h1;
		cfg.bus_link_function_setting = 2'h1;
		run(4, 11'h0018, 1'b1, 24, 1'b1);
		chk_bit(cmd_out.link_enable_cmd, 1'b1);
		run(0, 11'h0011, 1'b1, 17, 1'b0);
		field.host_write(16'h0004);
		run(0, 11'h0011, 1'b1, 17, 1'b1);
		run(4, NEG + 11'h0018, 1'b1, 24, 1'b0);
		run(0, 11'h0011, 1'b1, 17, 1'b1);
		run(0, 11'h0011, 1'b0, 17, 1'b0);
		run(4, NEG + 11'h0018, 1'b0, 24, 1'b1);
		run(0, 11'h000d, 1'b0, 13, 1'b0);
		run(0, 11'h000d, 1'b1, 13, 1'b1);
		run(0, 11'h0007, 1'b0, 7, 1'b1);
		field.host_write(16'h0000);
		run(0, 11'h0007, 1'b1, 7, 1'b1);
		run(0, 11'h0007, 1'b0, 7, 1'b0);
		field.host_write(16'h0040);
		run(4, NEG + 11'h001e, 1'b0, 30, 1'b1);
		clr();
		field.host_write(16'h0004);
		cfg.bus_link_function_setting = 2'h0;
		run(0, 11'h0011, 1'b0, 17, 1'b0);
		cfg.bus_option = 1'b1;
		run(0, 11'h0011, 1'b0, 17, 1'b1);
		field.host_write(16'h2000);
		run(5, 11'h0012, 1'b0, 18, 1'b1);
		field.host_write(16'h4000);
		run(6, 11'h0021, 1'b0, 33, 1'b1);
		chk_bit(func_out[18], 1'b0);
		stop_test();
	end
endmodule
